// File: src/vcch_top.sv
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "vcch_map.svh"
module vcch_top
    import vcch_pkg::*;
#(
    parameter int NV = 4,
    parameter int unsigned HOLD_CYCLES = `VC_HOLD_MS * `VC_CLK_KHZ,
    parameter int unsigned FLASH_CYCLES = `VC_FLASH_MS * `VC_CLK_KHZ,
    parameter int unsigned BLINK_CYCLES = `VC_BLINK_MS * `VC_CLK_KHZ,
    parameter int unsigned REPEAT_CYCLES = `VC_REPEAT_MS * `VC_CLK_KHZ
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    input wire logic up_sw_in,
    input wire logic down_sw_in,
    input wire logic enter_btn_in,
    input wire logic [1:0] tuning_selector_in,
    input wire logic modulate_in,
    input wire logic shutdown_in,
    input wire logic config_locked_in,
    input wire logic [1:0] selected_valve_in,
    input wire logic [15:0] input_current_ua_in,
    input wire logic [NV*`VC_POS_W-1:0] firing_pos_in,
    output logic [NV*`VC_POS_W-1:0] valve_pos_out,
    output logic [NV*`VC_POS_W-1:0] purge_pos_out,
    output logic input_dropout_out,
    output logic [9:0] number_lights_out,
    output logic manual_light_out,
    output logic run_light_out,
    output logic set_a_light_out,
    output logic irq_out
);
    localparam int PW = `VC_POS_W;

    // Valve index fits the two-bit select and the address field
    if (NV < 1 || NV > 4) begin
        $error("vcch_top: NV must be 1 to 4");
    end
    if (FLASH_CYCLES < 1 || BLINK_CYCLES < 1 || REPEAT_CYCLES < 1) begin
        $error("vcch_top: cycle counts must be at least 1");
    end

    // Whole state; the width depends on NV so it lives here
    typedef struct packed {
        logic [7:0] sy1;
        logic [7:0] sy2;
        logic [7:0] sy3;
        vcch_state_e state;
        logic [2:0] setting;
        logic [2:0] shown;
        logic lost;
        logic [1:0] vsel;
        logic [NV-1:0] custom;
        logic [NV-1:0][4:0][PW-1:0] pos;
        logic [PW-1:0] setup;
        logic [PW-1:0] base;
        logic [31:0] hold;
        logic [31:0] rep;
        logic [31:0] flash;
        logic [31:0] blink_cnt;
        logic blink;
        vcch_flash_e fkind;
        logic [3:0] ist;
        logic [3:0] imask;
        logic ack;
        logic [31:0] rdat;
        logic [NV-1:0][PW-1:0] vout;
        logic [NV-1:0][PW-1:0] pout;
        logic [9:0] lights;
        logic man;
        logic run;
        logic seta;
        logic irq;
    } vcch_regs_s;

    vcch_regs_s s_q;
    vcch_regs_s s_d;

    logic up;
    logic dn;
    logic ent;
    logic [1:0] tun;
    logic mod_on;
    logic shd;
    logic lck;
    logic up_r;
    logic dn_r;
    logic ent_r;
    logic req;
    logic lost;
    logic coarse;
    logic attempt;
    logic reject;
    logic [31:0] wm;
    logic [31:0] rd;
    logic [3:0] ev;
    logic [2:0] slot;
    logic [1:0] vidx;
    logic signed [11:0] tgt;
    logic signed [11:0] lo;
    logic signed [11:0] hi;
    logic signed [11:0] stp;

    // Second sync stage feeds logic; third only remembers for edges
    assign up = s_q.sy2[7];
    assign dn = s_q.sy2[6];
    assign ent = s_q.sy2[5];
    assign tun = s_q.sy2[4:3];
    assign mod_on = s_q.sy2[2];
    assign shd = s_q.sy2[1];
    assign lck = s_q.sy2[0];
    assign up_r = up & ~s_q.sy3[7];
    assign dn_r = dn & ~s_q.sy3[6];
    assign ent_r = ent & ~s_q.sy3[5];
    assign lost = input_current_ua_in < `VC_DROP_UA;
    assign req = wb_cyc_in & wb_stb_in & ~s_q.ack;
    assign wm = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign slot = wb_adr_in[4:2];
    assign vidx = wb_adr_in[6:5];

    // Refusal reasons for the purge command
    assign reject = mod_on | (tun == VC_TUN_MIN) | shd | lck | (32'(selected_valve_in) >= NV);

    // Held switch: coarse step once per repeat period after the hold time
    assign coarse = (up ^ dn) && (s_q.hold >= HOLD_CYCLES) && (s_q.rep >= REPEAT_CYCLES - 1);
    assign attempt = (up_r & ~dn) | (dn_r & ~up) | coarse;
    assign stp = coarse ? `VC_COARSE_STEP : `VC_FINE_STEP;

    // Travel window around the stored position, clipped to valve travel
    always_comb begin
        lo = $signed({2'h0, s_q.base}) - `VC_LIMIT;
        if (lo < 12'sh000) begin
            lo = 12'sh000;
        end
        hi = $signed({2'h0, s_q.base}) + `VC_LIMIT;
        if (hi > `VC_TRAVEL_MAX) begin
            hi = `VC_TRAVEL_MAX;
        end
        tgt = up ? $signed({2'h0, s_q.setup}) + stp : $signed({2'h0, s_q.setup}) - stp;
    end

    // Next state
    always_comb begin
        s_d = s_q;
        ev = 4'h0;
        rd = 32'h0;
        s_d.sy1 = {up_sw_in, down_sw_in, enter_btn_in, tuning_selector_in,
                   modulate_in, shutdown_in, config_locked_in};
        s_d.sy2 = s_q.sy1;
        s_d.sy3 = s_q.sy2;
        s_d.lost = lost;
        if (lost && !s_q.lost) begin
            ev[`VC_IRQ_DROP] = 1'b1;
        end

        // Momentary flash timer restores the base pattern when it runs out
        if (s_q.flash > 32'h1) begin
            s_d.flash = s_q.flash - 32'h1;
        end else begin
            s_d.flash = 32'h0;
            s_d.fkind = VC_FL_NONE;
        end

        // Free-running blink for the setup indication
        if (s_q.blink_cnt >= BLINK_CYCLES - 1) begin
            s_d.blink_cnt = 32'h0;
            s_d.blink = ~s_q.blink;
        end else begin
            s_d.blink_cnt = s_q.blink_cnt + 32'h1;
        end

        case (s_q.state)
            VC_DROP_SEL: begin
                // Shown value saturates at both ends
                if (up_r && !dn && s_q.shown < `VC_DROP_MAX) begin
                    s_d.shown = s_q.shown + 3'h1;
                end else if (dn_r && !up && s_q.shown > 3'h0) begin
                    s_d.shown = s_q.shown - 3'h1;
                end
                if (ent_r) begin
                    s_d.setting = s_q.shown;
                    s_d.state = VC_IDLE;
                    ev[`VC_IRQ_SAVE] = 1'b1;
                end
            end
            VC_PURGE_SET: begin
                if (up ^ dn) begin
                    if (s_q.hold < HOLD_CYCLES) begin
                        s_d.hold = s_q.hold + 32'h1;
                    end else begin
                        s_d.rep = coarse ? 32'h0 : s_q.rep + 32'h1;
                    end
                end else begin
                    s_d.hold = 32'h0;
                    s_d.rep = 32'h0;
                end
                if (attempt && tun != VC_TUN_FINE) begin
                    // Position frozen; only the lights answer
                    s_d.flash = FLASH_CYCLES;
                    s_d.fkind = VC_FL_FLASH;
                end else if (attempt) begin
                    if (tgt <= lo) begin
                        s_d.setup = PW'(lo);
                    end else if (tgt >= hi) begin
                        s_d.setup = PW'(hi);
                    end else begin
                        s_d.setup = PW'(tgt);
                    end
                    if (tgt <= lo || tgt >= hi) begin
                        s_d.flash = FLASH_CYCLES;
                        s_d.fkind = VC_FL_FLASH;
                        ev[`VC_IRQ_LIMIT] = 1'b1;
                    end
                end
                if (ent_r) begin
                    // Only Enter commits; the table holds the old value until then
                    for (int v = 0; v < NV; v++) begin
                        if (s_q.vsel == 2'(v)) begin
                            s_d.pos[v][`VC_SLOT_PURGE] = s_q.setup;
                            s_d.custom[v] = 1'b1;
                        end
                    end
                    s_d.base = s_q.setup;
                    s_d.flash = FLASH_CYCLES;
                    s_d.fkind = VC_FL_BLANK;
                    ev[`VC_IRQ_SAVE] = 1'b1;
                end
            end
            default: begin
                s_d.state = VC_IDLE;
            end
        endcase

        // Register bus; command writes take priority over the machine
        if (req) begin
            if (wb_adr_in == `VC_ADR_CMD) begin
                rd[1:0] = s_q.state;
                if (wb_we_in && wb_sel_in[0]) begin
                    if (wb_dat_in[7:0] == `VC_CMD_DROP) begin
                        s_d.state = VC_DROP_SEL;
                        s_d.shown = s_q.setting;
                    end else if (wb_dat_in[7:0] == `VC_CMD_PURGE && reject) begin
                        s_d.flash = FLASH_CYCLES;
                        s_d.fkind = VC_FL_FLASH;
                        ev[`VC_IRQ_REJECT] = 1'b1;
                    end else if (wb_dat_in[7:0] == `VC_CMD_PURGE) begin
                        s_d.state = VC_PURGE_SET;
                        s_d.vsel = selected_valve_in;
                        s_d.hold = 32'h0;
                        s_d.rep = 32'h0;
                        for (int v = 0; v < NV; v++) begin
                            if (selected_valve_in == 2'(v)) begin
                                s_d.setup = s_q.custom[v] ? s_q.pos[v][`VC_SLOT_PURGE]
                                                          : s_q.pos[v][`VC_SLOT_IDX9];
                                s_d.base = s_d.setup;
                            end
                        end
                    end else if (wb_dat_in[7:0] == `VC_CMD_EXIT) begin
                        s_d.state = VC_IDLE;
                    end
                end
            end else if (wb_adr_in == `VC_ADR_STATUS) begin
                rd[2:0] = s_q.setting;
                rd[6:4] = s_q.shown;
                rd[8] = s_q.lost;
                rd[12 +: NV] = s_q.custom;
                rd[17:16] = s_q.state;
                rd[19:18] = s_q.fkind;
            end else if (wb_adr_in == `VC_ADR_INT_ST) begin
                rd[3:0] = s_q.ist;
                if (!wb_we_in) begin
                    s_d.ist = 4'h0;
                end
            end else if (wb_adr_in == `VC_ADR_INT_MASK) begin
                rd[3:0] = s_q.imask;
                if (wb_we_in) begin
                    s_d.imask = (s_q.imask & ~wm[3:0]) | (wb_dat_in[3:0] & wm[3:0]);
                end
            end else if (wb_adr_in[`VC_ADR_POS_BIT] && 32'(vidx) < NV
                         && slot <= `VC_SLOT_PURGE) begin
                for (int v = 0; v < NV; v++) begin
                    if (vidx == 2'(v)) begin
                        rd[PW-1:0] = (slot == `VC_SLOT_PURGE) ? s_q.pout[v] : s_q.pos[v][slot];
                        // Purge slot is written only by the setup save
                        if (wb_we_in && slot < `VC_SLOT_PURGE) begin
                            s_d.pos[v][slot] = (s_q.pos[v][slot] & ~wm[PW-1:0])
                                               | (wb_dat_in[PW-1:0] & wm[PW-1:0]);
                        end
                    end
                end
            end
        end
        s_d.ack = req;
        s_d.rdat = req ? rd : 32'h0;

        // Events after the read-clear, so a new event is never lost
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.imask);

        // Valve targets: setup overrides, then dropout, then firing rate
        for (int v = 0; v < NV; v++) begin
            if (s_q.state == VC_PURGE_SET && s_q.vsel == 2'(v)) begin
                s_d.vout[v] = s_q.setup;
            end else if (lost) begin
                if (s_q.setting < `VC_DROP_MAX) begin
                    s_d.vout[v] = s_q.pos[v][s_q.setting];
                end
            end else begin
                s_d.vout[v] = firing_pos_in[v*PW +: PW];
            end
            s_d.pout[v] = s_q.custom[v] ? s_q.pos[v][`VC_SLOT_PURGE]
                                        : s_q.pos[v][`VC_SLOT_IDX9];
        end

        // Lights: base pattern, then momentary overlay
        s_d.lights = 10'h000;
        s_d.man = 1'b0;
        s_d.run = mod_on;
        s_d.seta = 1'b0;
        case (s_q.state)
            VC_DROP_SEL: begin
                s_d.lights = 10'h001 << s_q.shown;
            end
            VC_PURGE_SET: begin
                s_d.lights = s_q.blink ? `VC_LT_SETUP : 10'h000;
                s_d.man = s_q.blink;
                s_d.run = s_q.blink;
                s_d.seta = s_q.blink;
            end
            default: begin
                s_d.lights = 10'h000;
            end
        endcase
        if (s_d.fkind == VC_FL_FLASH) begin
            s_d.lights = `VC_LT_ALL;
        end else if (s_d.fkind == VC_FL_BLANK) begin
            s_d.lights = 10'h000;
            s_d.seta = 1'b0;
        end
    end

    // Single register bank; zero reset gives setting 0 and idle
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.rdat;
    assign valve_pos_out = s_q.vout;
    assign purge_pos_out = s_q.pout;
    assign input_dropout_out = s_q.lost;
    assign number_lights_out = s_q.lights;
    assign manual_light_out = s_q.man;
    assign run_light_out = s_q.run;
    assign set_a_light_out = s_q.seta;
    assign irq_out = s_q.irq;
endmodule

// File: src/vcch_map.svh
`ifndef VCCH_MAP_SVH
`define VCCH_MAP_SVH

// Clock and times
`define VC_CLK_KHZ 250000
`define VC_HOLD_MS 3000
`define VC_FLASH_MS 500
`define VC_BLINK_MS 250
`define VC_REPEAT_MS 200
// Positions in tenths of a degree
`define VC_POS_W 10
`define VC_FINE_STEP 12'h001
`define VC_COARSE_STEP 12'h005
`define VC_LIMIT 12'h050
`define VC_TRAVEL_MAX 12'h384
// Dropout threshold in microamps (0.05 mA)
`define VC_DROP_UA 16'h0032
`define VC_DROP_MAX 3'h4
`define VC_DROP_RESET 3'h0
`define VC_SLOT_IDX9 3'h3
`define VC_SLOT_PURGE 3'h4
// Light patterns
`define VC_LT_SETUP 10'h203
`define VC_LT_ALL 10'h3ff
// Register byte addresses
`define VC_ADR_CMD 8'h00
`define VC_ADR_STATUS 8'h04
`define VC_ADR_INT_ST 8'h08
`define VC_ADR_INT_MASK 8'h0c
// Position table: 0x80 + valve * 0x20 + slot * 4
`define VC_ADR_POS_BIT 7
// Command codes
`define VC_CMD_EXIT 8'h00
`define VC_CMD_DROP 8'h01
`define VC_CMD_PURGE 8'h02
// Interrupt bits
`define VC_IRQ_DROP 0
`define VC_IRQ_REJECT 1
`define VC_IRQ_SAVE 2
`define VC_IRQ_LIMIT 3
`endif

// File: src/vcch_pkg.sv
package vcch_pkg;
    typedef enum logic [1:0] {
        VC_IDLE = 2'b00,
        VC_DROP_SEL = 2'b01,
        VC_PURGE_SET = 2'b10
    } vcch_state_e;
    typedef enum logic [1:0] {
        VC_FL_NONE = 2'b00,
        VC_FL_FLASH = 2'b01,
        VC_FL_BLANK = 2'b10
    } vcch_flash_e;
    typedef enum logic [1:0] {
        VC_TUN_MIN = 2'b00,
        VC_TUN_INDEX = 2'b01,
        VC_TUN_FINE = 2'b10
    } vcch_tuning_e;
endpackage

// File: tb/vcch_chk_sva.sv
`timescale 1ns/1ns
module vcch_chk #(
    parameter int unsigned FLASH_CYCLES = 8
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic [31:0] wb_dat_out,
    input wire logic [15:0] input_current_ua_in,
    input wire logic input_dropout_out,
    input wire logic [9:0] number_lights_out,
    input wire logic manual_light_out,
    input wire logic run_light_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // Length of the last all-lights run; catches a flash cut short
    logic [31:0] run_q;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_q <= 32'h0;
        end else if (number_lights_out == 10'h3ff) begin
            run_q <= run_q + 32'h1;
        end else begin
            run_q <= 32'h0;
        end
    end
    // Bus handshake
    property p_ack_next;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle;
        !wb_ack_out |-> wb_dat_out == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    // Lost-input flag, one cycle behind the current
    property p_lost;
        input_current_ua_in < 16'h0032 |=> input_dropout_out;
    endproperty
    a_lost: assert property (p_lost) else $error("loss not flagged");
    property p_kept;
        input_current_ua_in >= 16'h0032 |=> !input_dropout_out;
    endproperty
    a_kept: assert property (p_kept) else $error("false loss");
    property p_flash_len;
        number_lights_out != 10'h3ff && run_q != 32'h0 |-> run_q >= FLASH_CYCLES;
    endproperty
    a_flash_len: assert property (p_flash_len) else $error("flash too short");
    property p_setup_lights;
        number_lights_out == 10'h203 |-> manual_light_out && run_light_out;
    endproperty
    a_setup_lights: assert property (p_setup_lights) else $error("setup lights apart");
    property p_shown_range;
        $onehot(number_lights_out) |-> number_lights_out[9:5] == 5'h0;
    endproperty
    a_shown_range: assert property (p_shown_range) else $error("shown past 4");
endmodule
bind vcch_top vcch_chk #(.FLASH_CYCLES(FLASH_CYCLES)) vcch_chk_inst (.clock_in, .reset_n_in,
    .wb_cyc_in, .wb_stb_in, .wb_ack_out, .wb_dat_out, .input_current_ua_in,
    .input_dropout_out, .number_lights_out, .manual_light_out, .run_light_out);

// File: tb/vcch_operator.sv
`timescale 1ns/1ns
module vcch_operator (
    input wire logic clock_in,
    output logic up_sw_out,
    output logic down_sw_out,
    output logic enter_btn_out
);
    logic [2:0] keys;
    // Released keys read as not pressed
    assign {enter_btn_out, down_sw_out, up_sw_out} = keys;
    initial begin
        keys = 3'h0;
    end
    // One push: 0 up, 1 down, 2 Enter; the gap covers the 3-edge sync
    task automatic push(input int key, input int hold);
        @(posedge clock_in);
        keys <= 3'(1 << key);
        repeat (hold) @(posedge clock_in);
        keys <= 3'h0;
        repeat (5) @(posedge clock_in);
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
`include "vcch_map.svh"
module tb_top import vcch_pkg::*;;
    localparam int FL = 8;
    logic clock_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
    logic up_sw_in, down_sw_in, enter_btn_in, modulate_in, shutdown_in, config_locked_in;
    logic input_dropout_out, manual_light_out, run_light_out, set_a_light_out, irq_out;
    logic [1:0] tuning_selector_in, selected_valve_in;
    logic [3:0] wb_sel_in;
    logic [7:0] wb_adr_in;
    logic [9:0] number_lights_out, b;
    logic [15:0] input_current_ua_in;
    logic [31:0] wb_dat_in, wb_dat_out, rd, seed;
    logic [39:0] firing_pos_in, valve_pos_out, purge_pos_out, fp;
    logic [9:0] pos [4][4];
    int num_errors, total_checks, cycles, st, d;
    vcch_top #(.HOLD_CYCLES(20), .FLASH_CYCLES(FL), .BLINK_CYCLES(4), .REPEAT_CYCLES(5))
        vcch_top_inst (.*);
    vcch_operator vcch_operator_inst (.clock_in(clock_in), .up_sw_out(up_sw_in),
        .down_sw_out(down_sw_in), .enter_btn_out(enter_btn_in));
    // 250 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Positions kept clear of the travel ends so the 8 degree window fits
    function automatic logic [9:0] rpos();
        return 10'(xs() % 700 + 100);
    endfunction
    function automatic logic [39:0] slot_vec(input int s);
        return {pos[3][s], pos[2][s], pos[1][s], pos[0][s]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pos(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t valves got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clock_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_dat_in <= dat;
        do @(posedge clock_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the thousand or so cycles needed
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        seed = 32'h0000ade2;
        {reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, modulate_in} = 5'h0;
        {shutdown_in, config_locked_in, selected_valve_in} = 4'h0;
        {wb_adr_in, wb_dat_in} = 40'h0;
        wb_sel_in = 4'hf;
        tuning_selector_in = VC_TUN_FINE;
        input_current_ua_in = 16'h03e8;
        firing_pos_in = {rpos(), rpos(), rpos(), rpos()};
        st = 0;
        tick(2);
        reset_n_in <= 1'b1;
        rchk(`VC_ADR_STATUS, 32'h0);
        rchk(`VC_ADR_INT_MASK, 32'h0);
        wb(1'b1, 8'h40, 32'hffff);
        rchk(8'h40, 32'h0);
        // Stored positions, then the default purge position
        for (int i = 0; i < 16; i++) begin
            pos[i / 4][i % 4] = rpos();
            wb(1'b1, 8'(8'h80 + i / 4 * 32 + i % 4 * 4), 32'(pos[i / 4][i % 4]));
        end
        for (int i = 0; i < 16; i++) begin
            rchk(8'(8'h80 + i / 4 * 32 + i % 4 * 4), 32'(pos[i / 4][i % 4]));
        end
        rchk(8'hd0, 32'(pos[2][3]));
        chk_pos(purge_pos_out, slot_vec(3));
        wb(1'b1, `VC_ADR_INT_MASK, 32'hf);
        // Every dropout setting, with clamps at 0 and 4
        for (int s = 0; s < 5; s++) begin
            wb(1'b1, `VC_ADR_CMD, 32'h1);
            tick(2);
            chk(32'(number_lights_out), 32'h1 << st);
            repeat (5) vcch_operator_inst.push(1, 1);
            repeat (s + (s == 4)) vcch_operator_inst.push(0, 1);
            chk(32'(number_lights_out), 32'h1 << s);
            rchk(`VC_ADR_STATUS, 32'h10000 | 32'(s << 4) | 32'(st));
            vcch_operator_inst.push(2, 1);
            st = s;
            chk(32'(irq_out), 32'h1);
            rchk(`VC_ADR_INT_ST, 32'h4);
            wb(1'b0, `VC_ADR_STATUS, 32'h0);
            chk(rd & 32'h30007, 32'(s));
            fp = {rpos(), rpos(), rpos(), rpos()};
            firing_pos_in <= fp;
            input_current_ua_in <= 16'h0032;
            tick(3);
            chk(32'(input_dropout_out), 32'h0);
            chk_pos(valve_pos_out, fp);
            input_current_ua_in <= 16'h0031;
            tick(3);
            firing_pos_in <= {rpos(), rpos(), rpos(), rpos()};
            tick(3);
            chk(32'(input_dropout_out), 32'h1);
            chk_pos(valve_pos_out, (s == 4) ? fp : slot_vec(s));
            rchk(`VC_ADR_INT_ST, 32'h1);
            input_current_ua_in <= 16'h03e8;
            tick(3);
        end
        // Each refusal cause, reject interrupt masked
        wb(1'b1, `VC_ADR_INT_MASK, 32'hd);
        for (int i = 0; i < 4; i++) begin
            modulate_in <= (i == 0);
            tuning_selector_in <= (i == 1) ? VC_TUN_MIN : VC_TUN_FINE;
            shutdown_in <= (i == 2);
            config_locked_in <= (i == 3);
            tick(5);
            wb(1'b1, `VC_ADR_CMD, 32'h2);
            tick(1);
            chk(32'(number_lights_out), 32'h3ff);
            chk(32'(irq_out), 32'h0);
            rchk(`VC_ADR_INT_ST, 32'h2);
            tick(FL + 2);
            chk(32'(number_lights_out), 32'h0);
            rchk(`VC_ADR_CMD, 32'h0);
        end
        // Accepted purge setup on valve 1
        config_locked_in <= 1'b0;
        selected_valve_in <= 2'h1;
        wb(1'b1, `VC_ADR_INT_MASK, 32'hf);
        tick(4);
        wb(1'b1, `VC_ADR_CMD, 32'h2);
        b = pos[1][3];
        rchk(`VC_ADR_CMD, 32'h2);
        d = 0;
        repeat (12) begin
            @(posedge clock_in);
            if (number_lights_out === `VC_LT_SETUP && manual_light_out === 1'b1
                && run_light_out === 1'b1 && set_a_light_out === 1'b1) begin
                d = 1;
            end
        end
        chk(32'(d), 32'h1);
        chk(32'(valve_pos_out[19:10]), 32'(b));
        vcch_operator_inst.push(0, 1);
        chk(32'(valve_pos_out[19:10]), 32'(b) + 32'h1);
        vcch_operator_inst.push(1, 1);
        chk(32'(valve_pos_out[19:10]), 32'(b));
        tuning_selector_in <= VC_TUN_INDEX;
        tick(4);
        vcch_operator_inst.push(0, 1);
        chk(32'(valve_pos_out[19:10]), 32'(b));
        tuning_selector_in <= VC_TUN_FINE;
        tick(4);
        vcch_operator_inst.push(0, 40);
        d = int'(valve_pos_out[19:10]) - int'(b);
        chk(32'(d % 5 == 1 && d > 1), 32'h1);
        vcch_operator_inst.push(0, 200);
        chk(32'(valve_pos_out[19:10]), 32'(b) + 32'h50);
        chk(32'(purge_pos_out[19:10]), 32'(b));
        rchk(`VC_ADR_INT_ST, 32'h8);
        vcch_operator_inst.push(2, 1);
        d = 0;
        // Blink alone would light something within six cycles
        repeat (6) begin
            if ({number_lights_out, set_a_light_out} !== 11'h000) begin
                d = 1;
            end
            @(posedge clock_in);
        end
        chk(32'(d), 32'h0);
        chk(32'(purge_pos_out[19:10]), 32'(b) + 32'h50);
        rchk(8'hb0, 32'(b) + 32'h50);
        wb(1'b0, `VC_ADR_STATUS, 32'h0);
        chk(32'(rd[13]), 32'h1);
        rchk(`VC_ADR_INT_ST, 32'h4);
        wb(1'b1, `VC_ADR_CMD, 32'h0);
        rchk(`VC_ADR_CMD, 32'h0);
        tally_and_finish();
    end
endmodule
